// ===== rtl/dpsr_defines.svh
// Purpose: Shared constants for the burst SRAM link
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef DPSR_DEFINES_SVH
`define DPSR_DEFINES_SVH

// Data and address widths of the two configurations
`define DPSR_DW_NARROW 18
`define DPSR_AW_NARROW 20
`define DPSR_DW_WIDE   36
`define DPSR_AW_WIDE   19

// One byte lane of write data
`define DPSR_LANE_W 9

// Burst of four beats, two address bits per burst word
`define DPSR_BURST    4
`define DPSR_BEAT_AW  2
`define DPSR_BEAT_0   2'h0
`define DPSR_BEAT_1   2'h1
`define DPSR_BEAT_2   2'h2
`define DPSR_BEAT_3   2'h3
`define DPSR_LEFT_M1  3'h3
`define DPSR_LEFT_0   3'h0

`endif

// ===== rtl/dpsr_pkg.sv
// Purpose: Types used by the controller end of the burst SRAM link
// Assumes: Constants come from dpsr_defines.svh
// Notes: Phase of the link clock divider in the controller
package dpsr_pkg;

   // Quarter phases of one link clock cycle
   typedef enum logic [1:0] {
      DPSR_PH_RISE = 2'b00,
      DPSR_PH_HI   = 2'b01,
      DPSR_PH_FALL = 2'b10,
      DPSR_PH_LO   = 2'b11
   } dpsr_phase_t;

endpackage

// ===== rtl/dpsr_link_if.sv
// Purpose: Pin bundle between memory controller and burst SRAM
// Assumes: Controller makes both input clocks
// Notes: q_oe marks the read bus as driven by the device
`timescale 1ns/1ns
`include "dpsr_defines.svh"
interface dpsr_link_if #(
   parameter int DW = `DPSR_DW_NARROW,
   parameter int AW = `DPSR_AW_NARROW
);
   localparam int BW = DW / `DPSR_LANE_W;

   logic          k;        // Positive input clock
   logic          k_n;      // Negative input clock
   logic [AW-1:0] addr;     // Shared address
   logic          write_port_select_n;
   logic          read_port_select_n;
   logic [BW-1:0] byte_lane_write_select_n;
   logic [DW-1:0] d;        // Write data
   logic [DW-1:0] q;        // Read data
   logic          q_oe;     // Read data driven
   logic          read_beat_valid;
   logic          echo_clock;
   logic          echo_clock_n;

   modport ctrl (
      output k, k_n, addr, write_port_select_n, read_port_select_n,
             byte_lane_write_select_n, d,
      input  q, q_oe, read_beat_valid, echo_clock, echo_clock_n
   );
   modport dev (
      input  k, k_n, addr, write_port_select_n, read_port_select_n,
             byte_lane_write_select_n, d,
      output q, q_oe, read_beat_valid, echo_clock, echo_clock_n
   );
endinterface

// ===== rtl/dpsr_device.sv
// Purpose: Device end of a DDR burst SRAM with separate ports
// Assumes: k and k_n complementary, driven by the controller
// Notes: Storage depth set by MAW; echo clocks mirror k and k_n
//
// Overview of operation
// R1 - Write data taken on both clock rises
// R2 - Low write select at k starts write
// R3 - Deselected write port ignores write data
// R4 - Byte selects sampled per beat, others kept
// R5 - Each select governs one nine-bit lane
// R6 - Controller aligns byte selects with data beat
// R7 - Shared address captured at k rise
// R8 - Address width per configuration, four arrays
// R9 - Address ignored for deselected port
// R10 - Read data driven on both clock rises
// R11 - Idle read port floats its outputs
// R12 - Low read select at k starts read
// R13 - Finish pending read, float after k
// R14 - Every read delivers exactly four beats
// R15 - Beat valid aligned with echo clocks
// R16 - Accesses start only on k rise
// R17 - k_n rise captures inputs, launches beats
// R18 - Free-running echo clock pair from k
// R19 - PLL disable selects one-cycle read latency
// R20 - PLL on: first beat two cycles later
// R21 - Controller alternates read and write slots
`timescale 1ns/1ns
`include "dpsr_defines.svh"
module dpsr_device #(
   parameter int DW  = `DPSR_DW_NARROW,
   parameter int AW  = `DPSR_AW_NARROW,
   parameter int MAW = AW
) (
   dpsr_link_if.dev    link,
   input  wire logic   RST_N_I,
   input  wire logic   PLL_DISABLE_N_I,
   output      logic   PLL_ON_O
);
   localparam int LW = `DPSR_LANE_W;
   localparam int BW = DW / LW;
   localparam int IW = MAW + `DPSR_BEAT_AW;

   // Four arrays, one per burst word, interleaved
   logic [DW-1:0] mem_r [0:(1 << IW) - 1]; // R8

   logic          rst_s1_r;
   logic          rst_k_n_r;
   logic          pll_s1_r;
   logic          pll_on_r;

   logic          wr_cmd;
   logic          wr_act_r;
   logic          wr_commit_r;
   logic [AW-1:0] wr_addr_r;
   logic [DW-1:0] wb0_r;
   logic [DW-1:0] wb1_r;
   logic [DW-1:0] wb2_r;
   logic [DW-1:0] wb3_r;
   logic [BW-1:0] wm0_r;
   logic [BW-1:0] wm1_r;
   logic [BW-1:0] wm2_r;
   logic [BW-1:0] wm3_r;

   logic          rd_cmd;
   logic          rd_v1_r;
   logic          rd_v2_r;
   logic [AW-1:0] rd_a1_r;
   logic [AW-1:0] rd_a2_r;
   logic          launch;
   logic [AW-1:0] launch_addr;
   logic          rd_hi_r;
   logic [AW-1:0] rd_ha_r;
   logic [DW-1:0] q_pos_r;
   logic [DW-1:0] q_neg_r;
   logic [DW-1:0] nb_r;
   logic          vpos_r;
   logic          vneg_r;

   // Storage index of one burst word
   function automatic logic [IW-1:0] idx(
      input logic [AW-1:0] a,
      input logic [1:0]    b
   );
      return {a[MAW-1:0], b};
   endfunction

   // Merge selected lanes of a beat into the old word
   function automatic logic [DW-1:0] merge(
      input logic [DW-1:0] old_w,
      input logic [DW-1:0] new_w,
      input logic [BW-1:0] sel_n
   );
      logic [DW-1:0] res;
      res = old_w;
      for (int i = 0; i < BW; i++) begin
         if (!sel_n[i]) begin
            res[i*LW +: LW] = new_w[i*LW +: LW]; // R5
         end
      end
      return res;
   endfunction

   // Reset released in step with k
   always_ff @(posedge link.k or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_s1_r  <= 1'b0;
         rst_k_n_r <= 1'b0;
      end else begin
         rst_s1_r  <= 1'b1;
         rst_k_n_r <= rst_s1_r;
      end
   end

   // Static PLL strap, two flops deep
   always_ff @(posedge link.k or negedge rst_k_n_r) begin
      if (!rst_k_n_r) begin
         pll_s1_r <= 1'b1;
         pll_on_r <= 1'b1;
      end else begin
         pll_s1_r <= PLL_DISABLE_N_I;
         pll_on_r <= pll_s1_r; // R19
      end
   end

   assign PLL_ON_O = pll_on_r;

   // Command decode at k rise; busy port ignores select
   assign wr_cmd = !link.write_port_select_n && !wr_act_r; // R2 R16
   assign rd_cmd = !link.read_port_select_n && !rd_v1_r;   // R12 R16

   // Write burst: beats 0 and 2 on k, commit after beat 3
   always_ff @(posedge link.k or negedge rst_k_n_r) begin
      if (!rst_k_n_r) begin
         wr_act_r    <= 1'b0;
         wr_commit_r <= 1'b0;
         wr_addr_r   <= '0;
         wb0_r       <= '0;
         wb2_r       <= '0;
         wm0_r       <= '1;
         wm2_r       <= '1;
      end else begin
         wr_act_r    <= wr_cmd;
         wr_commit_r <= wr_act_r;
         if (wr_cmd) begin
            wr_addr_r <= link.addr;                // R7 R9
            wb0_r     <= link.d;                   // R1 R3
            wm0_r     <= link.byte_lane_write_select_n; // R4 R6
         end
         if (wr_act_r) begin
            wb2_r <= link.d;                       // R1
            wm2_r <= link.byte_lane_write_select_n; // R4
         end
      end
   end

   // Write burst: beats 1 and 3 on k_n
   always_ff @(posedge link.k_n or negedge rst_k_n_r) begin
      if (!rst_k_n_r) begin
         wb1_r <= '0;
         wb3_r <= '0;
         wm1_r <= '1;
         wm3_r <= '1;
      end else begin
         if (wr_act_r) begin
            wb1_r <= link.d;                       // R1 R17
            wm1_r <= link.byte_lane_write_select_n; // R4
         end
         if (wr_commit_r) begin
            wb3_r <= link.d;                       // R1 R17
            wm3_r <= link.byte_lane_write_select_n; // R4
         end
      end
   end

   // Whole burst written at once, unselected lanes kept
   always_ff @(posedge link.k) begin
      if (wr_commit_r && rst_k_n_r) begin
         mem_r[idx(wr_addr_r, `DPSR_BEAT_0)] <=
            merge(mem_r[idx(wr_addr_r, `DPSR_BEAT_0)], wb0_r, wm0_r); // R4
         mem_r[idx(wr_addr_r, `DPSR_BEAT_1)] <=
            merge(mem_r[idx(wr_addr_r, `DPSR_BEAT_1)], wb1_r, wm1_r);
         mem_r[idx(wr_addr_r, `DPSR_BEAT_2)] <=
            merge(mem_r[idx(wr_addr_r, `DPSR_BEAT_2)], wb2_r, wm2_r);
         mem_r[idx(wr_addr_r, `DPSR_BEAT_3)] <=
            merge(mem_r[idx(wr_addr_r, `DPSR_BEAT_3)], wb3_r, wm3_r);
      end
   end

   // Read latency pipe: one stage with PLL off, two with it on
   always_ff @(posedge link.k or negedge rst_k_n_r) begin
      if (!rst_k_n_r) begin
         rd_v1_r <= 1'b0;
         rd_v2_r <= 1'b0;
         rd_a1_r <= '0;
         rd_a2_r <= '0;
      end else begin
         rd_v1_r <= rd_cmd;
         rd_v2_r <= rd_v1_r;
         if (rd_cmd) begin
            rd_a1_r <= link.addr; // R7 R9
         end
         rd_a2_r <= rd_a1_r;
      end
   end

   // Launch point chosen by PLL mode
   assign launch      = pll_on_r ? rd_v2_r : rd_v1_r; // R19 R20
   assign launch_addr = pll_on_r ? rd_a2_r : rd_a1_r;

   // Beats 0 and 2 launched on k, 1 and 3 staged for k_n
   always_ff @(posedge link.k or negedge rst_k_n_r) begin
      if (!rst_k_n_r) begin
         rd_hi_r <= 1'b0;
         rd_ha_r <= '0;
         q_pos_r <= '0;
         nb_r    <= '0;
         vpos_r  <= 1'b0;
      end else begin
         rd_hi_r <= launch;
         if (launch) begin
            rd_ha_r <= launch_addr;
            q_pos_r <= mem_r[idx(launch_addr, `DPSR_BEAT_0)]; // R10
            nb_r    <= mem_r[idx(launch_addr, `DPSR_BEAT_1)];
            vpos_r  <= 1'b1;
         end else if (rd_hi_r) begin
            q_pos_r <= mem_r[idx(rd_ha_r, `DPSR_BEAT_2)];     // R14
            nb_r    <= mem_r[idx(rd_ha_r, `DPSR_BEAT_3)];
            vpos_r  <= 1'b1;
         end else begin
            vpos_r  <= 1'b0; // R13
         end
      end
   end

   // Odd beats launched on k_n
   always_ff @(posedge link.k_n or negedge rst_k_n_r) begin
      if (!rst_k_n_r) begin
         q_neg_r <= '0;
         vneg_r  <= 1'b0;
      end else begin
         q_neg_r <= nb_r;   // R10 R17
         vneg_r  <= vpos_r; // R13
      end
   end

   // Output half selected by clock level, floated when idle
   assign link.q               = link.k ? q_pos_r : q_neg_r; // R10
   assign link.read_beat_valid = link.k ? vpos_r : vneg_r;   // R15
   assign link.q_oe            = link.read_beat_valid;       // R11 R13

   // Echo clocks follow the input clocks
   assign link.echo_clock   = link.k;   // R18
   assign link.echo_clock_n = link.k_n; // R18

endmodule // dpsr_device

// ===== rtl/dpsr_ctrl.sv
// Purpose: Memory controller end of the burst SRAM link
// Assumes: Link clock is CLK_SYS_I divided by four
// Notes: Reads in even link cycles, writes in odd ones
`timescale 1ns/1ns
`include "dpsr_defines.svh"
module dpsr_ctrl #(
   parameter int DW = `DPSR_DW_NARROW,
   parameter int AW = `DPSR_AW_NARROW
) (
   input  wire logic                 CLK_SYS_I,
   input  wire logic                 RST_N_I,
   input  wire logic                 WR_REQ_I,
   input  wire logic [AW-1:0]        WR_ADDR_I,
   input  wire logic [4*DW-1:0]      WR_DATA_I,
   input  wire logic [4*DW/`DPSR_LANE_W-1:0] WR_BE_N_I,
   output      logic                 WR_READY_O,
   input  wire logic                 RD_REQ_I,
   input  wire logic [AW-1:0]        RD_ADDR_I,
   output      logic                 RD_READY_O,
   output      logic                 RD_VALID_O,
   output      logic [4*DW-1:0]      RD_DATA_O,
   dpsr_link_if.ctrl                 link
);
   localparam int BW = DW / `DPSR_LANE_W;

   dpsr_pkg::dpsr_phase_t ph_r;
   dpsr_pkg::dpsr_phase_t ph_nxt;
   logic              k_nxt;
   logic              k_r;
   logic              k_n_r;
   logic              slot_wr_r;
   logic              setup_rise;
   logic              setup_fall;
   logic              wr_issue;
   logic              rd_issue;
   logic              wr_pend_r;
   logic              rd_pend_r;
   logic [AW-1:0]     wr_addr_r;
   logic [AW-1:0]     rd_addr_r;
   logic [4*DW-1:0]   wsh_d_r;
   logic [4*BW-1:0]   wsh_m_r;
   logic [2:0]        wr_left_r;
   logic [AW-1:0]     addr_r;
   logic              wps_n_r;
   logic              rps_n_r;
   logic [BW-1:0]     bws_n_r;
   logic [DW-1:0]     d_r;
   logic [DW-1:0]     q_s1_r;
   logic [DW-1:0]     q_s2_r;
   logic              v_s1_r;
   logic              v_s2_r;
   logic [4*DW-1:0]   rd_sh_r;
   logic [1:0]        rd_cnt_r;
   logic              sample;
   logic              wr_take;
   logic              rd_take;
   logic              wr_shift;
   logic              wr_pend_nxt;
   logic              rd_pend_nxt;
   logic [2:0]        wr_left_nxt;

   // Divider phase sequence
   always_comb begin
      case (ph_r)
         dpsr_pkg::DPSR_PH_RISE: ph_nxt = dpsr_pkg::DPSR_PH_HI;
         dpsr_pkg::DPSR_PH_HI:   ph_nxt = dpsr_pkg::DPSR_PH_FALL;
         dpsr_pkg::DPSR_PH_FALL: ph_nxt = dpsr_pkg::DPSR_PH_LO;
         default:                ph_nxt = dpsr_pkg::DPSR_PH_RISE;
      endcase
   end

   // Pins change mid half-cycle, away from clock edges
   assign k_nxt = (ph_nxt == dpsr_pkg::DPSR_PH_RISE) ||
                  (ph_nxt == dpsr_pkg::DPSR_PH_HI);
   assign setup_rise = (ph_r == dpsr_pkg::DPSR_PH_FALL);
   assign setup_fall = (ph_r == dpsr_pkg::DPSR_PH_RISE);
   assign sample     = setup_rise || setup_fall;
   assign wr_issue   = setup_rise && slot_wr_r && wr_pend_r; // R21
   assign rd_issue   = setup_rise && !slot_wr_r && rd_pend_r; // R21

   // Take a request only while ready; next holding and beat count
   assign wr_take     = WR_REQ_I && WR_READY_O;
   assign rd_take     = RD_REQ_I && RD_READY_O;
   assign wr_shift    = wr_issue ||
                        (sample && wr_left_r != `DPSR_LEFT_0);
   assign wr_left_nxt = wr_issue ? `DPSR_LEFT_M1 :
                        wr_shift ? 3'(wr_left_r - 3'h1) : wr_left_r;
   assign wr_pend_nxt = wr_take || (wr_pend_r && !wr_issue);
   assign rd_pend_nxt = rd_take || (rd_pend_r && !rd_issue);

   // Clock divider and slot parity
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ph_r      <= dpsr_pkg::DPSR_PH_LO;
         k_r       <= 1'b0;
         k_n_r     <= 1'b1;
         slot_wr_r <= 1'b1;
      end else begin
         ph_r  <= ph_nxt;
         k_r   <= k_nxt;
         k_n_r <= !k_nxt;
         if (setup_rise) begin
            slot_wr_r <= !slot_wr_r;
         end
      end
   end

   // Request holding; write ready waits for the last beat to leave
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wr_pend_r  <= 1'b0;
         rd_pend_r  <= 1'b0;
         wr_addr_r  <= '0;
         rd_addr_r  <= '0;
         WR_READY_O <= 1'b1;
         RD_READY_O <= 1'b1;
      end else begin
         wr_pend_r  <= wr_pend_nxt;
         rd_pend_r  <= rd_pend_nxt;
         WR_READY_O <= !wr_pend_nxt && (wr_left_nxt == `DPSR_LEFT_0);
         RD_READY_O <= !rd_pend_nxt;
         if (wr_take) begin
            wr_addr_r <= WR_ADDR_I;
         end
         if (rd_take) begin
            rd_addr_r <= RD_ADDR_I;
         end
      end
   end

   // Write burst shifter; new data never cuts into a running burst
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wsh_d_r   <= '0;
         wsh_m_r   <= '1;
         wr_left_r <= `DPSR_LEFT_0;
         addr_r    <= '0;
         wps_n_r   <= 1'b1;
         rps_n_r   <= 1'b1;
         bws_n_r   <= '1;
         d_r       <= '0;
      end else begin
         wr_left_r <= wr_left_nxt;
         if (wr_take) begin
            wsh_d_r <= WR_DATA_I;
            wsh_m_r <= WR_BE_N_I;
         end else if (wr_shift) begin
            d_r     <= wsh_d_r[DW-1:0];   // R1
            bws_n_r <= wsh_m_r[BW-1:0];   // R4 R6
            wsh_d_r <= wsh_d_r >> DW;
            wsh_m_r <= wsh_m_r >> BW;
         end else if (sample) begin
            bws_n_r <= '1;
         end
         if (setup_rise) begin
            wps_n_r <= !wr_issue;           // R2
            rps_n_r <= !rd_issue;           // R12
            if (wr_issue) begin
               addr_r <= wr_addr_r;         // R7
            end else if (rd_issue) begin
               addr_r <= rd_addr_r;         // R7
            end
         end
      end
   end

   // Read beats: two flops, then sampled mid beat
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q_s1_r     <= '0;
         q_s2_r     <= '0;
         v_s1_r     <= 1'b0;
         v_s2_r     <= 1'b0;
         rd_sh_r    <= '0;
         rd_cnt_r   <= 2'h0;
         RD_VALID_O <= 1'b0;
         RD_DATA_O  <= '0;
      end else begin
         q_s1_r     <= link.q_oe ? link.q : '0;
         q_s2_r     <= q_s1_r;
         v_s1_r     <= link.read_beat_valid;
         v_s2_r     <= v_s1_r;
         RD_VALID_O <= 1'b0;
         if (sample && v_s2_r) begin
            rd_sh_r  <= {q_s2_r, rd_sh_r[4*DW-1:DW]};
            rd_cnt_r <= 2'(rd_cnt_r + 2'h1);
            if (rd_cnt_r == `DPSR_BEAT_3) begin
               RD_VALID_O <= 1'b1;          // R14
               RD_DATA_O  <= {q_s2_r, rd_sh_r[4*DW-1:DW]};
            end
         end
      end
   end

   // Pins from flops
   assign link.k                        = k_r;
   assign link.k_n                      = k_n_r;
   assign link.addr                     = addr_r;
   assign link.write_port_select_n      = wps_n_r;
   assign link.read_port_select_n       = rps_n_r;
   assign link.byte_lane_write_select_n = bws_n_r;
   assign link.d                        = d_r;

endmodule // dpsr_ctrl

// ===== verification/dpsr_link_props.sv
// Purpose: Concurrent checks on the burst SRAM link pins
// Assumes: Both ends share RST_N_I; k drives all sampling except one echo check clocked by k_n
// Notes: Latency depends on the device strap seen on PLL_ON_O
`timescale 1ns/1ns
module dpsr_link_props (
   input wire logic k,
   input wire logic k_n,
   input wire logic RST_N_I,
   input wire logic PLL_ON_O,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic q_oe,
   input wire logic read_beat_valid,
   input wire logic echo_clock,
   input wire logic echo_clock_n
);
   // All link checks but a_echo_at_fall sample on the positive input clock
   default clocking cb @(posedge k);
   endclocking
   default disable iff (!RST_N_I);

   // With the loop on, read drivers float once a lone burst has been delivered
   a_float_after_read: assert property (
      !read_port_select_n && PLL_ON_O ##1 read_port_select_n [*2]
      |-> ##3 !q_oe)
      else $error("read drivers still enabled after burst end");

   // Echo pair mirrors the input clocks at both edges
   a_echo_at_rise: assert property (
      echo_clock == k && echo_clock_n == k_n)
      else $error("echo clocks differ from input clocks at k rise");
   a_echo_at_fall: assert property (@(posedge k_n) disable iff (!RST_N_I)
      echo_clock == k && echo_clock_n == k_n)
      else $error("echo clocks differ from input clocks at k_n rise");

   // Read latency two link cycles with the loop on, one with it off
   a_read_lat_on: assert property (
      !read_port_select_n && PLL_ON_O |-> ##3 read_beat_valid [*2])
      else $error("read beats missing after two cycle latency");
   a_read_lat_off: assert property (
      !read_port_select_n && !PLL_ON_O |-> ##2 read_beat_valid [*2])
      else $error("read beats missing after one cycle latency");

   // Valid beats only in the four beat window of a read
   a_valid_has_read: assert property (read_beat_valid |->
      (PLL_ON_O ? (!$past(read_port_select_n, 3) ||
                   !$past(read_port_select_n, 4))
                : (!$past(read_port_select_n, 2) ||
                   !$past(read_port_select_n, 3))))
      else $error("beat valid without a read in range");

   // Each command holds its select for one link cycle
   a_read_one_cycle: assert property (
      !read_port_select_n |=> read_port_select_n)
      else $error("read select held beyond one cycle");
   a_write_one_cycle: assert property (
      !write_port_select_n |=> write_port_select_n)
      else $error("write select held beyond one cycle");

   // Read and write commands never share a k rise
   a_slots_apart: assert property (
      !read_port_select_n |-> write_port_select_n)
      else $error("read and write issued on the same edge");
endmodule // dpsr_link_props

// ===== verification/tb_top.sv
// Purpose: Self-checking bench joining controller and device ends
// Assumes: Link clock made by the controller from CLK_SYS_I
// Notes: Device storage shrunk through MAW; addresses stay below 64
`timescale 1ns/1ns
`include "dpsr_defines.svh"
module tb_top;
   localparam int DW = `DPSR_DW_NARROW;
   localparam int AW = `DPSR_AW_NARROW;
   localparam int WW = 4 * DW;
   localparam int LW = 4 * DW / `DPSR_LANE_W;
   localparam logic [WW-1:0] PAT_A = 72'h123456789ABCDEF012;
   localparam logic [WW-1:0] PAT_B = 72'hFEDCBA9876543210AB;

   logic          clk_sys, rst_n, pll_disable_n, pll_on;
   logic          wr_req, wr_ready, rd_req, rd_ready, rd_valid;
   logic [AW-1:0] wr_addr, rd_addr;
   logic [WW-1:0] wr_data, rd_data, got, got2;
   logic [LW-1:0] wr_be_n;
   int            n_mismatch, samples_checked;
   wire  [DW-1:0] q_pin;

   dpsr_link_if #(.DW(DW), .AW(AW)) u_dpsr_link_if ();
   dpsr_ctrl #(.DW(DW), .AW(AW)) u_dpsr_ctrl (
      .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .WR_REQ_I(wr_req),
      .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data), .WR_BE_N_I(wr_be_n),
      .WR_READY_O(wr_ready), .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr),
      .RD_READY_O(rd_ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
      .link(u_dpsr_link_if.ctrl));
   dpsr_device #(.DW(DW), .AW(AW), .MAW(6)) u_dpsr_device (
      .link(u_dpsr_link_if.dev), .RST_N_I(rst_n),
      .PLL_DISABLE_N_I(pll_disable_n), .PLL_ON_O(pll_on));
   dpsr_link_props u_dpsr_link_props (
      .k(u_dpsr_link_if.k), .k_n(u_dpsr_link_if.k_n), .RST_N_I(rst_n),
      .PLL_ON_O(pll_on),
      .write_port_select_n(u_dpsr_link_if.write_port_select_n),
      .read_port_select_n(u_dpsr_link_if.read_port_select_n),
      .q_oe(u_dpsr_link_if.q_oe),
      .read_beat_valid(u_dpsr_link_if.read_beat_valid),
      .echo_clock(u_dpsr_link_if.echo_clock),
      .echo_clock_n(u_dpsr_link_if.echo_clock_n));

   // Read bus as seen on the wires, floating while not driven
   assign q_pin = u_dpsr_link_if.q_oe ? u_dpsr_link_if.q : 'z;

   // System clock, 100 ns period
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Compare and count
   task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Lane merge: a high select keeps the old lane
   function automatic logic [WW-1:0] merge(input logic [WW-1:0] old_w,
      input logic [WW-1:0] new_w, input logic [LW-1:0] be_n);
      logic [WW-1:0] r;
      for (int l = 0; l < LW; l++) begin
         r[l*`DPSR_LANE_W +: `DPSR_LANE_W] = be_n[l] ?
            old_w[l*`DPSR_LANE_W +: `DPSR_LANE_W] :
            new_w[l*`DPSR_LANE_W +: `DPSR_LANE_W];
      end
      return r;
   endfunction

   // Write request held through the edge where ready is seen
   task automatic do_write(input logic [AW-1:0] a, input logic [WW-1:0] dat,
      input logic [LW-1:0] be_n);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (wr_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 50) n_mismatch++;
      wr_req = 1'b1;
      wr_addr = a;
      wr_data = dat;
      wr_be_n = be_n;
      @(negedge clk_sys);
      wr_req = 1'b0;
   endtask

   task automatic rd_issue(input logic [AW-1:0] a);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (rd_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 50) n_mismatch++;
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge clk_sys);
      rd_req = 1'b0;
   endtask

   // Wait for the completion pulse, bounded
   task automatic rd_collect(output logic [WW-1:0] dat);
      int n;
      n = 0;
      while (rd_valid !== 1'b1 && n < 80) begin
         @(negedge clk_sys);
         n++;
      end
      dat = (n < 80) ? rd_data : 'x;
      @(negedge clk_sys);
   endtask

   task automatic do_read(input logic [AW-1:0] a, output logic [WW-1:0] dat);
      rd_issue(a);
      rd_collect(dat);
   endtask

   // Idle link after reset: outputs floated, loop on
   task automatic t_idle;
      check(WW'({u_dpsr_link_if.q_oe, u_dpsr_link_if.read_beat_valid,
         wr_ready, rd_ready, pll_on}), WW'(5'h07));
      check(WW'(q_pin), WW'({DW{1'bz}}));
   endtask

   // Full bursts land at their own addresses
   task automatic t_write_read;
      do_write(20'h00005, PAT_A, 8'h00);
      do_write(20'h0003F, PAT_B, 8'h00);
      do_read(20'h00005, got);
      check(got, PAT_A);
      do_read(20'h0003F, got);
      check(got, PAT_B);
   endtask

   // Per beat lane selects, then a fully masked write
   task automatic t_byte_lanes;
      do_write(20'h00009, PAT_A, 8'h00);
      do_write(20'h00009, PAT_B, 8'hA5);
      do_read(20'h00009, got);
      check(got, merge(PAT_A, PAT_B, 8'hA5));
      do_write(20'h00009, PAT_A ^ PAT_B, 8'hFF);
      do_read(20'h00009, got2);
      check(got2, got);
   endtask

   // Write and read together, then two reads back to back
   task automatic t_concurrent;
      fork
         do_write(20'h00012, PAT_B, 8'h00);
         do_read(20'h00005, got);
      join
      check(got, PAT_A);
      rd_issue(20'h00012);
      rd_issue(20'h0003F);
      rd_collect(got);
      rd_collect(got2);
      check(got, PAT_B);
      check(got2, PAT_B);
   endtask

   // Strapped loop off, one cycle latency, then restored
   task automatic t_pll_off;
      @(negedge clk_sys);
      rst_n = 1'b0;
      pll_disable_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (16) @(negedge clk_sys);
      check(WW'(pll_on), WW'(1'b0));
      do_write(20'h00020, PAT_A, 8'h3C);
      do_write(20'h00020, PAT_B, 8'hC3);
      // Let the second burst commit before it is read back
      repeat (8) @(negedge clk_sys);
      do_read(20'h00020, got);
      check(got, merge(PAT_A, PAT_B, 8'hC3));
      rst_n = 1'b0;
      pll_disable_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (16) @(negedge clk_sys);
      check(WW'(pll_on), WW'(1'b1));
   endtask

   // Main sequence
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      pll_disable_n = 1'b1;
      wr_req = 1'b0;
      rd_req = 1'b0;
      wr_addr = '0;
      rd_addr = '0;
      wr_data = '0;
      wr_be_n = '1;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (16) @(negedge clk_sys);
      t_idle();
      t_write_read();
      t_byte_lanes();
      t_concurrent();
      t_pll_off();
      tally_and_finish();
   end

   // Hang guard
   initial begin
      repeat (6000) @(posedge clk_sys);
      n_mismatch++;
      tally_and_finish();
   end
endmodule // tb_top
